// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
// Three-stage pin synchroniser; output changes once stages two and three agree
module pin_sync (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic pin_in,
  output logic      level_out
);

  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic       level_reg;
  logic       level_next;

  // ************************************************************
  // Next values
  // ************************************************************
  always_comb begin
    stage_next = {stage_reg[1:0], pin_in};
    level_next = level_reg;
    if (stage_reg[1] == stage_reg[2]) begin
      level_next = stage_reg[2];
    end
  end

  // Registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      stage_reg <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

endmodule

// *** rtl/pmu_regs_pkg.sv ***
package pmu_regs_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] SYSTEM_CONTROL_OFFSET          = 8'h00;
  localparam logic [7:0] SCRATCHPAD_OFFSET              = 8'h01;
  localparam logic [7:0] BUCK1_PRIMARY_VOLTAGE_OFFSET   = 8'h20;
  localparam logic [7:0] BUCK1_SECONDARY_VOLTAGE_OFFSET = 8'h21;
  localparam logic [7:0] BUCK1_CONTROL_OFFSET           = 8'h22;
  localparam logic [7:0] BUCK2_PRIMARY_VOLTAGE_OFFSET   = 8'h30;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int RESET_TIMER_BIT     = 7;
  localparam int RESPONSE_SELECT_BIT = 6;
  localparam int MONITOR_IRQ_BIT     = 5;
  localparam int SUPPLY_LOW_BIT      = 4;
  localparam int ENABLE_BIT          = 7;
  localparam int PHASE_BIT           = 6;
  localparam int MODE_BIT            = 5;
  localparam int DELAY_LSB           = 2;
  localparam int FAULT_IRQ_BIT       = 1;
  localparam int POWER_GOOD_BIT      = 0;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h00;
  localparam logic [3:0] SPARE_RESET          = 4'h0;
  localparam logic [5:0] BUCK1_PRIMARY_RESET  = 6'h00;
  localparam logic [5:0] BUCK1_SECOND_RESET   = 6'h00;
  localparam logic [2:0] DELAY_RESET          = 3'h0;
  localparam logic [5:0] BUCK2_PRIMARY_RESET  = 6'h00;

  // ************************************************************
  // Reset time-out figures and cycle counts at 200 MHz
  // ************************************************************
  localparam longint CLOCK_HZ         = 200000000;
  localparam longint SHORT_TIMEOUT_MS = 65;
  localparam longint LONG_TIMEOUT_MS  = 260;
  localparam longint SHORT_TIMEOUT_CYCLES = SHORT_TIMEOUT_MS * CLOCK_HZ / 1000;
  localparam longint LONG_TIMEOUT_CYCLES  = LONG_TIMEOUT_MS * CLOCK_HZ / 1000;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

endpackage

// *** rtl/pmu_system_regulator_regs.sv ***
`timescale 1ns/1ps
module pmu_system_regulator_regs #(
  parameter longint SHORT_TIMEOUT = pmu_regs_pkg::SHORT_TIMEOUT_CYCLES,
  parameter longint LONG_TIMEOUT  = pmu_regs_pkg::LONG_TIMEOUT_CYCLES
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       VOLTAGE_CHOICE_PIN,
  input  wire logic       SUPPLY_BELOW_THRESHOLD,
  input  wire logic       BUCK1_POWER_GOOD,
  input  wire logic       BUCK1_FAULT,
  input  wire logic       SYSTEM_SHUTDOWN,
  input  wire logic       INPUT_UNDERVOLTAGE,
  input  wire logic       RESET_TRIGGER,
  output logic            RESET_OUTPUT_PIN_N,
  output logic      [3:0] SUPPLY_MONITOR_THRESHOLD,
  output logic            MONITOR_IRQ,
  output logic            MONITOR_SHUTDOWN,
  output logic            BUCK1_FAULT_IRQ,
  output logic      [5:0] BUCK1_VOLTAGE,
  output logic      [5:0] BUCK2_VOLTAGE,
  output logic            BUCK1_ENABLE,
  output logic            BUCK1_ANTI_PHASE,
  output logic            BUCK1_FORCED_PWM,
  output logic      [2:0] BUCK1_TURN_ON_DELAY
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic sel_sync;
  logic low_sync;
  logic pgood_sync;
  logic fault_sync;
  logic shut_sync;
  logic uvlo_sync;
  logic rst_trig_sync;

  pin_sync u_sel   (.CLK(CLK), .RST_N(RST_N), .pin_in(VOLTAGE_CHOICE_PIN),     .level_out(sel_sync));
  pin_sync u_low   (.CLK(CLK), .RST_N(RST_N), .pin_in(SUPPLY_BELOW_THRESHOLD), .level_out(low_sync));
  pin_sync u_pgood (.CLK(CLK), .RST_N(RST_N), .pin_in(BUCK1_POWER_GOOD),       .level_out(pgood_sync));
  pin_sync u_fault (.CLK(CLK), .RST_N(RST_N), .pin_in(BUCK1_FAULT),            .level_out(fault_sync));
  pin_sync u_shut  (.CLK(CLK), .RST_N(RST_N), .pin_in(SYSTEM_SHUTDOWN),        .level_out(shut_sync));
  pin_sync u_uvlo  (.CLK(CLK), .RST_N(RST_N), .pin_in(INPUT_UNDERVOLTAGE),     .level_out(uvlo_sync));
  pin_sync u_rtrig (.CLK(CLK), .RST_N(RST_N), .pin_in(RESET_TRIGGER),          .level_out(rst_trig_sync));

  // ************************************************************
  // Register state
  // ************************************************************
  logic       reset_timer_reg;
  logic       reset_timer_next;
  logic       response_select_reg;
  logic       response_select_next;
  logic       monitor_irq_enable_reg;
  logic       monitor_irq_enable_next;
  logic [3:0] threshold_reg;
  logic [3:0] threshold_next;
  logic [3:0] spare_reg;
  logic [3:0] spare_next;
  logic [5:0] b1_primary_reg;
  logic [5:0] b1_primary_next;
  logic [5:0] b1_second_reg;
  logic [5:0] b1_second_next;
  logic       b1_enable_reg;
  logic       b1_enable_next;
  logic       b1_phase_reg;
  logic       b1_phase_next;
  logic       b1_mode_reg;
  logic       b1_mode_next;
  logic [2:0] b1_delay_reg;
  logic [2:0] b1_delay_next;
  logic       fault_irq_enable_reg;
  logic       fault_irq_enable_next;
  logic [5:0] b2_primary_reg;
  logic [5:0] b2_primary_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Register writes; hardware clears take priority over a write in the same cycle
  always_comb begin
    reset_timer_next        = reset_timer_reg;
    response_select_next    = response_select_reg;
    monitor_irq_enable_next = monitor_irq_enable_reg;
    threshold_next          = threshold_reg;
    spare_next              = spare_reg;
    b1_primary_next         = b1_primary_reg;
    b1_second_next          = b1_second_reg;
    b1_enable_next          = b1_enable_reg;
    b1_phase_next           = b1_phase_reg;
    b1_mode_next            = b1_mode_reg;
    b1_delay_next           = b1_delay_reg;
    fault_irq_enable_next   = fault_irq_enable_reg;
    b2_primary_next         = b2_primary_reg;
    if (WR) begin
      case (ADDR)
        pmu_regs_pkg::SYSTEM_CONTROL_OFFSET: begin
          reset_timer_next        = WDATA[pmu_regs_pkg::RESET_TIMER_BIT];
          response_select_next    = WDATA[pmu_regs_pkg::RESPONSE_SELECT_BIT];
          monitor_irq_enable_next = WDATA[pmu_regs_pkg::MONITOR_IRQ_BIT];
          threshold_next          = WDATA[3:0];
        end
        pmu_regs_pkg::SCRATCHPAD_OFFSET:              spare_next      = WDATA[3:0];
        pmu_regs_pkg::BUCK1_PRIMARY_VOLTAGE_OFFSET:   b1_primary_next = WDATA[5:0];
        pmu_regs_pkg::BUCK1_SECONDARY_VOLTAGE_OFFSET: b1_second_next  = WDATA[5:0];
        pmu_regs_pkg::BUCK1_CONTROL_OFFSET: begin
          b1_enable_next        = WDATA[pmu_regs_pkg::ENABLE_BIT];
          b1_phase_next         = WDATA[pmu_regs_pkg::PHASE_BIT];
          b1_mode_next          = WDATA[pmu_regs_pkg::MODE_BIT];
          b1_delay_next         = WDATA[pmu_regs_pkg::DELAY_LSB +: 3];
          fault_irq_enable_next = WDATA[pmu_regs_pkg::FAULT_IRQ_BIT];
        end
        pmu_regs_pkg::BUCK2_PRIMARY_VOLTAGE_OFFSET:   b2_primary_next = WDATA[5:0];
        default: begin
        end
      endcase
    end
    if (shut_sync) begin
      spare_next = pmu_regs_pkg::SPARE_RESET;
    end
    if (uvlo_sync) begin
      b1_delay_next = pmu_regs_pkg::DELAY_RESET;
    end
  end

  // Read mux; data stand in the cycle after the strobe only
  always_comb begin
    rdata_next = 8'h00;
    if (RD) begin
      case (ADDR)
        pmu_regs_pkg::SYSTEM_CONTROL_OFFSET:
          rdata_next = {reset_timer_reg, response_select_reg, monitor_irq_enable_reg,
                        low_sync, threshold_reg};
        pmu_regs_pkg::SCRATCHPAD_OFFSET:              rdata_next = {4'h0, spare_reg};
        pmu_regs_pkg::BUCK1_PRIMARY_VOLTAGE_OFFSET:   rdata_next = {2'h0, b1_primary_reg};
        pmu_regs_pkg::BUCK1_SECONDARY_VOLTAGE_OFFSET: rdata_next = {2'h0, b1_second_reg};
        pmu_regs_pkg::BUCK1_CONTROL_OFFSET:
          rdata_next = {b1_enable_reg, b1_phase_reg, b1_mode_reg, b1_delay_reg,
                        fault_irq_enable_reg, pgood_sync};
        pmu_regs_pkg::BUCK2_PRIMARY_VOLTAGE_OFFSET:   rdata_next = {2'h0, b2_primary_reg};
        default:                                      rdata_next = 8'h00;
      endcase
    end
  end

  // ************************************************************
  // Reset output timer
  // ************************************************************
  logic [31:0] timer_reg;
  logic [31:0] timer_next;
  logic        rst_out_n_reg;
  logic        rst_out_n_next;

  // Hold reset out low while triggered, then count the chosen time-out
  always_comb begin
    timer_next     = timer_reg;
    rst_out_n_next = rst_out_n_reg;
    if (rst_trig_sync) begin
      rst_out_n_next = 1'b0;
      timer_next     = reset_timer_reg ? 32'(SHORT_TIMEOUT) : 32'(LONG_TIMEOUT);
    end else if (timer_reg > 32'h0000_0001) begin
      timer_next = timer_reg - 32'h0000_0001;
    end else begin
      timer_next     = 32'h0000_0000;
      rst_out_n_next = 1'b1;
    end
  end

  // ************************************************************
  // Derived outputs
  // ************************************************************
  logic       mon_irq_reg;
  logic       mon_irq_next;
  logic       mon_shut_reg;
  logic       mon_shut_next;
  logic       fault_irq_reg;
  logic       fault_irq_next;
  logic [5:0] b1_volt_reg;
  logic [5:0] b1_volt_next;

  // Monitor response, interrupt gating and voltage selection
  always_comb begin
    mon_irq_next   = low_sync & response_select_reg & monitor_irq_enable_reg;
    mon_shut_next  = low_sync & ~response_select_reg;
    fault_irq_next = fault_sync & fault_irq_enable_reg;
    b1_volt_next   = sel_sync ? b1_second_reg : b1_primary_reg;
  end

  // Registers; reset timer starts at long time-out so reset output is held at power-up
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      reset_timer_reg        <= pmu_regs_pkg::SYSTEM_CONTROL_RESET[pmu_regs_pkg::RESET_TIMER_BIT];
      response_select_reg    <= pmu_regs_pkg::SYSTEM_CONTROL_RESET[pmu_regs_pkg::RESPONSE_SELECT_BIT];
      monitor_irq_enable_reg <= pmu_regs_pkg::SYSTEM_CONTROL_RESET[pmu_regs_pkg::MONITOR_IRQ_BIT];
      threshold_reg          <= pmu_regs_pkg::SYSTEM_CONTROL_RESET[3:0];
      spare_reg              <= pmu_regs_pkg::SPARE_RESET;
      b1_primary_reg         <= pmu_regs_pkg::BUCK1_PRIMARY_RESET;
      b1_second_reg          <= pmu_regs_pkg::BUCK1_SECOND_RESET;
      b1_enable_reg          <= 1'b0;
      b1_phase_reg           <= 1'b0;
      b1_mode_reg            <= 1'b0;
      b1_delay_reg           <= pmu_regs_pkg::DELAY_RESET;
      fault_irq_enable_reg   <= 1'b0;
      b2_primary_reg         <= pmu_regs_pkg::BUCK2_PRIMARY_RESET;
      rdata_reg              <= 8'h00;
      timer_reg              <= 32'(LONG_TIMEOUT);
      rst_out_n_reg          <= 1'b0;
      mon_irq_reg            <= 1'b0;
      mon_shut_reg           <= 1'b0;
      fault_irq_reg          <= 1'b0;
      b1_volt_reg            <= pmu_regs_pkg::BUCK1_PRIMARY_RESET;
    end else begin
      reset_timer_reg        <= reset_timer_next;
      response_select_reg    <= response_select_next;
      monitor_irq_enable_reg <= monitor_irq_enable_next;
      threshold_reg          <= threshold_next;
      spare_reg              <= spare_next;
      b1_primary_reg         <= b1_primary_next;
      b1_second_reg          <= b1_second_next;
      b1_enable_reg          <= b1_enable_next;
      b1_phase_reg           <= b1_phase_next;
      b1_mode_reg            <= b1_mode_next;
      b1_delay_reg           <= b1_delay_next;
      fault_irq_enable_reg   <= fault_irq_enable_next;
      b2_primary_reg         <= b2_primary_next;
      rdata_reg              <= rdata_next;
      timer_reg              <= timer_next;
      rst_out_n_reg          <= rst_out_n_next;
      mon_irq_reg            <= mon_irq_next;
      mon_shut_reg           <= mon_shut_next;
      fault_irq_reg          <= fault_irq_next;
      b1_volt_reg            <= b1_volt_next;
    end
  end

  // Outputs straight from flip-flops
  assign RDATA                    = rdata_reg;
  assign RESET_OUTPUT_PIN_N       = rst_out_n_reg;
  assign SUPPLY_MONITOR_THRESHOLD = threshold_reg;
  assign MONITOR_IRQ              = mon_irq_reg;
  assign MONITOR_SHUTDOWN         = mon_shut_reg;
  assign BUCK1_FAULT_IRQ          = fault_irq_reg;
  assign BUCK1_VOLTAGE            = b1_volt_reg;
  assign BUCK2_VOLTAGE            = b2_primary_reg;
  assign BUCK1_ENABLE             = b1_enable_reg;
  assign BUCK1_ANTI_PHASE         = b1_phase_reg;
  assign BUCK1_FORCED_PWM         = b1_mode_reg;
  assign BUCK1_TURN_ON_DELAY      = b1_delay_reg;

endmodule

// *** verif/pmu_regs_properties.sv ***
`timescale 1ns/1ps
// ************************************************************
// Register bank checker
// ************************************************************
module pmu_regs_checker #(
  parameter longint SHORT_TIMEOUT = 20,
  parameter longint LONG_TIMEOUT  = 80
) (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       VOLTAGE_CHOICE_PIN,
  input wire logic       RESET_TRIGGER,
  input wire logic       RESET_OUTPUT_PIN_N,
  input wire logic [3:0] SUPPLY_MONITOR_THRESHOLD,
  input wire logic       MONITOR_IRQ,
  input wire logic       MONITOR_SHUTDOWN,
  input wire logic       BUCK1_FAULT_IRQ,
  input wire logic [5:0] BUCK1_VOLTAGE,
  input wire logic [5:0] BUCK2_VOLTAGE,
  input wire logic       BUCK1_ENABLE,
  input wire logic       BUCK1_ANTI_PHASE,
  input wire logic       BUCK1_FORCED_PWM
);
  logic [2:0]  sys_reg, sys_next;
  logic        fault_en_reg, fault_en_next;
  logic [5:0]  prim_reg, prim_next, sec_reg, sec_next;
  logic [31:0] tcnt_reg, tcnt_next, lim;
  logic        lim_sel_reg, lim_sel_next;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Shadow of control bits; outputs may lag a cycle, so both ages are accepted
  always_comb begin
    sys_next = sys_reg;
    fault_en_next = fault_en_reg;
    prim_next = prim_reg;
    sec_next = sec_reg;
    if (WR && ADDR == 8'h00) sys_next = WDATA[7:5];
    if (WR && ADDR == 8'h22) fault_en_next = WDATA[1];
    if (WR && ADDR == 8'h20) prim_next = WDATA[5:0];
    if (WR && ADDR == 8'h21) sec_next = WDATA[5:0];
    tcnt_next = RESET_TRIGGER ? 32'h0 : tcnt_reg + 32'h1;
    // Time-out choice is latched by the trigger, not by later writes
    lim_sel_next = RESET_TRIGGER ? sys_reg[2] : lim_sel_reg;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sys_reg <= 3'h0;
      fault_en_reg <= 1'b0;
      prim_reg <= 6'h00;
      sec_reg <= 6'h00;
      tcnt_reg <= 32'h0;
      lim_sel_reg <= 1'b0;
    end else begin
      lim_sel_reg <= lim_sel_next;
      sys_reg <= sys_next;
      fault_en_reg <= fault_en_next;
      prim_reg <= prim_next;
      sec_reg <= sec_next;
      tcnt_reg <= tcnt_next;
    end
  end

  // Time-out in force; slack covers the pin synchroniser
  assign lim = lim_sel_reg ? 32'(SHORT_TIMEOUT) : 32'(LONG_TIMEOUT);

  a_ctrl_bits_write: assert property (WR && ADDR == 8'h22 |=>
    {BUCK1_ENABLE, BUCK1_ANTI_PHASE, BUCK1_FORCED_PWM} == $past(WDATA[7:5]))
    else $error("control outputs differ from written bits");
  a_threshold_write: assert property (WR && ADDR == 8'h00 |=>
    SUPPLY_MONITOR_THRESHOLD == $past(WDATA[3:0])) else $error("threshold not taken");
  a_buck2_code: assert property (WR && ADDR == 8'h30 |=>
    BUCK2_VOLTAGE == $past(WDATA[5:0])) else $error("second regulator code not taken");
  a_primary_code: assert property (!VOLTAGE_CHOICE_PIN [*8] |->
    BUCK1_VOLTAGE == prim_reg || BUCK1_VOLTAGE == $past(prim_reg))
    else $error("primary code not in use while select is low");
  a_secondary_code: assert property (VOLTAGE_CHOICE_PIN [*8] |->
    BUCK1_VOLTAGE == sec_reg || BUCK1_VOLTAGE == $past(sec_reg))
    else $error("secondary code not in use while select is high");
  a_monitor_irq_gate: assert property (MONITOR_IRQ |->
    sys_reg[1:0] == 2'b11 || $past(sys_reg[1:0]) == 2'b11) else $error("monitor irq not enabled");
  a_shutdown_mode: assert property (MONITOR_SHUTDOWN |->
    !sys_reg[1] || !$past(sys_reg[1])) else $error("shutdown while interrupt mode chosen");
  a_fault_irq_gate: assert property (BUCK1_FAULT_IRQ |->
    fault_en_reg || $past(fault_en_reg)) else $error("fault irq while masked");
  a_reset_out_held: assert property (RESET_TRIGGER [*8] |-> !RESET_OUTPUT_PIN_N)
    else $error("reset output released under trigger");
  a_reset_out_time: assert property ($rose(RESET_OUTPUT_PIN_N) |->
    tcnt_reg >= lim && tcnt_reg <= lim + 32'hC) else $error("reset output time-out wrong");
  a_reserved_zero: assert property (RD && ADDR == 8'h01 |=> RDATA[7:4] == 4'h0)
    else $error("reserved scratchpad bits not zero");

  c_monitor_irq: cover property (MONITOR_IRQ);
  c_reset_release: cover property ($rose(RESET_OUTPUT_PIN_N));
  c_secondary: cover property (VOLTAGE_CHOICE_PIN [*8] ##0 BUCK1_VOLTAGE == sec_reg);
endmodule

bind pmu_system_regulator_regs pmu_regs_checker #(
  .SHORT_TIMEOUT(SHORT_TIMEOUT), .LONG_TIMEOUT(LONG_TIMEOUT)) chk (
  .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .VOLTAGE_CHOICE_PIN(VOLTAGE_CHOICE_PIN), .RESET_TRIGGER(RESET_TRIGGER),
  .RESET_OUTPUT_PIN_N(RESET_OUTPUT_PIN_N), .SUPPLY_MONITOR_THRESHOLD(SUPPLY_MONITOR_THRESHOLD),
  .MONITOR_IRQ(MONITOR_IRQ), .MONITOR_SHUTDOWN(MONITOR_SHUTDOWN),
  .BUCK1_FAULT_IRQ(BUCK1_FAULT_IRQ), .BUCK1_VOLTAGE(BUCK1_VOLTAGE),
  .BUCK2_VOLTAGE(BUCK2_VOLTAGE), .BUCK1_ENABLE(BUCK1_ENABLE),
  .BUCK1_ANTI_PHASE(BUCK1_ANTI_PHASE), .BUCK1_FORCED_PWM(BUCK1_FORCED_PWM));

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata;} row_type;
  // Short time-outs keep the run brief
  localparam int SHORT_T = 20;
  localparam int LONG_T  = 80;
  logic CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, VOLTAGE_CHOICE_PIN = 1'b0;
  logic SUPPLY_BELOW_THRESHOLD = 1'b0, BUCK1_POWER_GOOD = 1'b0, BUCK1_FAULT = 1'b0;
  logic SYSTEM_SHUTDOWN = 1'b0, INPUT_UNDERVOLTAGE = 1'b0, RESET_TRIGGER = 1'b0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
  logic RESET_OUTPUT_PIN_N, MONITOR_IRQ, MONITOR_SHUTDOWN, BUCK1_FAULT_IRQ;
  logic BUCK1_ENABLE, BUCK1_ANTI_PHASE, BUCK1_FORCED_PWM;
  logic [3:0] SUPPLY_MONITOR_THRESHOLD;
  logic [5:0] BUCK1_VOLTAGE, BUCK2_VOLTAGE;
  logic [2:0] BUCK1_TURN_ON_DELAY;
  int fail_count = 0, total_checks = 0, cycles = 0;
  logic [7:0] regs [6] = '{8'h00, 8'h01, 8'h20, 8'h21, 8'h22, 8'h30};
  // Write, expected readback; status bits low, 0x44 unmapped
  row_type rows [8] = '{'{8'h00, 8'hFF, 8'hEF}, '{8'h01, 8'hFF, 8'h0F},
    '{8'h20, 8'hFF, 8'h3F}, '{8'h21, 8'hAA, 8'h2A}, '{8'h22, 8'hFF, 8'hFE},
    '{8'h22, 8'h54, 8'h54}, '{8'h30, 8'hC5, 8'h05}, '{8'h44, 8'hFF, 8'h00}};

  pmu_system_regulator_regs #(.SHORT_TIMEOUT(SHORT_T), .LONG_TIMEOUT(LONG_T)) dut (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .VOLTAGE_CHOICE_PIN(VOLTAGE_CHOICE_PIN), .SUPPLY_BELOW_THRESHOLD(SUPPLY_BELOW_THRESHOLD),
    .BUCK1_POWER_GOOD(BUCK1_POWER_GOOD), .BUCK1_FAULT(BUCK1_FAULT),
    .SYSTEM_SHUTDOWN(SYSTEM_SHUTDOWN), .INPUT_UNDERVOLTAGE(INPUT_UNDERVOLTAGE),
    .RESET_TRIGGER(RESET_TRIGGER), .RESET_OUTPUT_PIN_N(RESET_OUTPUT_PIN_N),
    .SUPPLY_MONITOR_THRESHOLD(SUPPLY_MONITOR_THRESHOLD), .MONITOR_IRQ(MONITOR_IRQ),
    .MONITOR_SHUTDOWN(MONITOR_SHUTDOWN), .BUCK1_FAULT_IRQ(BUCK1_FAULT_IRQ),
    .BUCK1_VOLTAGE(BUCK1_VOLTAGE), .BUCK2_VOLTAGE(BUCK2_VOLTAGE), .BUCK1_ENABLE(BUCK1_ENABLE),
    .BUCK1_ANTI_PHASE(BUCK1_ANTI_PHASE), .BUCK1_FORCED_PWM(BUCK1_FORCED_PWM),
    .BUCK1_TURN_ON_DELAY(BUCK1_TURN_ON_DELAY));

  // ************************************************************
  // Clock, watchdog and closing report
  // ************************************************************
  always #2.5 CLK = ~CLK;

  // A hang counts as a mismatch
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ************************************************************
  // Bus cycles and comparison
  // ************************************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 check("read data", exp, RDATA);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // Trigger the reset output and time its release from the trigger's fall
  task automatic reset_out(input logic [7:0] sys, input int lo);
    int n;
    n = 0;
    wr(8'h00, sys);
    RESET_TRIGGER <= 1'b1;
    idle(10);
    #1 check("reset out held", 8'h00, {7'h0, RESET_OUTPUT_PIN_N});
    @(posedge CLK);
    RESET_TRIGGER <= 1'b0;
    while (RESET_OUTPUT_PIN_N !== 1'b1 && n < 300) begin
      @(posedge CLK);
      #1;
      n++;
    end
    check("reset out time", 8'h01, {7'h0, n >= lo && n <= lo + 12});
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    idle(5);
    RST_N <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rdata);
    end
    #1 check("control outputs", 8'h15, {2'h0, BUCK1_ENABLE, BUCK1_ANTI_PHASE,
      BUCK1_FORCED_PWM, BUCK1_TURN_ON_DELAY});
    $display("table test done");
    // Voltage select pin picks the code of the first regulator
    wr(8'h20, 8'h15);
    wr(8'h21, 8'h2A);
    wr(8'h30, 8'h33);
    idle(8);
    #1 check("codes select low", 8'h53, {BUCK1_VOLTAGE[3:0], BUCK2_VOLTAGE[3:0]});
    @(posedge CLK);
    VOLTAGE_CHOICE_PIN <= 1'b1;
    idle(8);
    #1 check("code select high", 8'h2A, {2'h0, BUCK1_VOLTAGE});
    @(posedge CLK);
    VOLTAGE_CHOICE_PIN <= 1'b0;
    $display("voltage select test done");
    // Supply monitor: interrupt response, masked, then shutdown response
    wr(8'h00, 8'h63);
    SUPPLY_BELOW_THRESHOLD <= 1'b1;
    idle(8);
    #1 check("monitor irq", 8'h02, {6'h0, MONITOR_IRQ, MONITOR_SHUTDOWN});
    rd(8'h00, 8'h73);
    wr(8'h00, 8'h43);
    idle(8);
    #1 check("monitor masked", 8'h00, {6'h0, MONITOR_IRQ, MONITOR_SHUTDOWN});
    wr(8'h00, 8'h03);
    idle(8);
    #1 check("monitor shutdown", 8'h01, {6'h0, MONITOR_IRQ, MONITOR_SHUTDOWN});
    @(posedge CLK);
    SUPPLY_BELOW_THRESHOLD <= 1'b0;
    BUCK1_FAULT <= 1'b1;
    BUCK1_POWER_GOOD <= 1'b1;
    idle(8);
    rd(8'h00, 8'h03);
    $display("supply monitor test done");
    // Fault interrupt gate and power-good status
    wr(8'h22, 8'h02);
    idle(8);
    #1 check("fault irq", 8'h01, {7'h0, BUCK1_FAULT_IRQ});
    rd(8'h22, 8'h03);
    wr(8'h22, 8'h00);
    idle(8);
    #1 check("fault masked", 8'h00, {7'h0, BUCK1_FAULT_IRQ});
    @(posedge CLK);
    BUCK1_FAULT <= 1'b0;
    BUCK1_POWER_GOOD <= 1'b0;
    $display("fault test done");
    // Shutdown clears the scratchpad, undervoltage clears the delay
    wr(8'h01, 8'h0A);
    wr(8'h22, 8'h1C);
    SYSTEM_SHUTDOWN <= 1'b1;
    INPUT_UNDERVOLTAGE <= 1'b1;
    idle(8);
    SYSTEM_SHUTDOWN <= 1'b0;
    INPUT_UNDERVOLTAGE <= 1'b0;
    idle(8);
    rd(8'h01, 8'h00);
    rd(8'h22, 8'h00);
    $display("clearing test done");
    reset_out(8'h80, SHORT_T);
    reset_out(8'h00, LONG_T);
    $display("reset output test done");
    // Second reset in mid-run returns every register to zero
    @(posedge CLK);
    RST_N <= 1'b0;
    idle(5);
    RST_N <= 1'b1;
    #1 check("reset out after reset", 8'h00, {7'h0, RESET_OUTPUT_PIN_N});
    foreach (regs[i]) begin
      rd(regs[i], 8'h00);
    end
    $display("reset test done");
    stop_test();
  end
endmodule
